// *** spc_checker.sv ***
// Concurrent checks on the parameter service and pin-2 action outputs
`timescale 1ns/1ns
module spc_checker (
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic        req_in,
  input wire logic        req_write_in,
  input wire logic [7:0]  req_index_in,
  input wire logic [7:0]  req_sub_in,
  input wire logic [3:0]  req_len_in,
  input wire logic [63:0] req_data_in,
  input wire logic        req_block_end_in,
  input wire logic        app_busy_in,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_err_out,
  input wire logic [7:0]  rsp_code_out,
  input wire logic [7:0]  rsp_add_out,
  input wire logic [63:0] rsp_data_out,
  input wire logic        teach_out,
  input wire logic        principle_static_out,
  input wire logic        output_nc_out,
  input wire logic        diag_clear_out
);
  // --------------------
  // Request decode helpers
  // --------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  wire svc   = req_in && !req_block_end_in; // Single access, not block end
  wire known = req_index_in inside {8'h02, 8'h47, 8'h4c, 8'h54};
  wire clr   = svc && req_write_in && req_index_in == 8'h02 && req_sub_in == 8'h00 &&
               req_len_in == 4'h1 && req_data_in[7:0] == 8'ha3;
  // --------------------
  // Answers
  // --------------------
  rsp_timing_a: assert property (rsp_valid_out == $past(req_in))
    else $error("answer strobe not one cycle after request");
  err_code_a: assert property (rsp_valid_out |-> (rsp_err_out ? rsp_code_out == 8'h80 :
      (rsp_code_out == 8'h00 && rsp_add_out == 8'h00))) else $error("bad error code");
  bad_index_a: assert property (svc && !known |=> rsp_err_out && rsp_add_out == 8'h11)
    else $error("unknown index not refused");
  bad_sub_a: assert property (svc && req_index_in == 8'h54 && req_sub_in > 8'h02 |=>
      rsp_err_out && rsp_add_out == 8'h12) else $error("unknown subindex not refused");
  ro_write_a: assert property (svc && req_write_in && req_index_in == 8'h54 && req_sub_in <= 8'h02
      |=> rsp_err_out && rsp_add_out == 8'h23) else $error("write to record not refused");
  len_long_a: assert property (svc && req_write_in && req_index_in == 8'h47 && req_sub_in == 8'h00 &&
      req_len_in > 4'h1 |=> rsp_add_out == 8'h33) else $error("long write not refused");
  busy_cmd_a: assert property (clr && app_busy_in |=> rsp_err_out && rsp_add_out == 8'h36 &&
      !diag_clear_out) else $error("busy command not refused");
  diag_clear_a: assert property (clr && !app_busy_in |=> diag_clear_out && !rsp_err_out)
    else $error("clear command without clear pulse");
  err_data_a: assert property (rsp_err_out |-> rsp_valid_out && rsp_data_out == 64'h0)
    else $error("refused answer carries data");
  // --------------------
  // Pin-2 actions
  // --------------------
  teach_pulse_a: assert property (teach_out |=> !teach_out)
    else $error("teach pulse longer than one cycle");
  one_action_a: assert property (teach_out || $changed(output_nc_out) |-> $stable(principle_static_out) &&
      !(teach_out && $changed(output_nc_out))) else $error("more than one action at release");
endmodule : spc_checker

bind spc_top spc_checker spc_checker_i (.*);

// *** spc_lim_if.sv ***
// Interface carrying the limit tracker signals
`timescale 1ns/1ns
interface spc_lim_if;
  logic        sample; // New measured value valid
  logic [31:0] value;  // Measured value
  logic        clear;  // Reset limits
  logic [31:0] min;    // Lowest value seen
  logic [31:0] max;    // Highest value seen
  modport ctl (output sample, output value, output clear, input min, input max);
  modport trk (input sample, input value, input clear, output min, output max);
endinterface : spc_lim_if

// *** spc_lim_track.sv ***
// Minimum and maximum tracker for measured values
`timescale 1ns/1ns
module spc_lim_track (
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  spc_lim_if.trk    lim
);

  logic [31:0] min_ff; // Lowest value
  logic [31:0] max_ff; // Highest value

  assign lim.min = min_ff;
  assign lim.max = max_ff;

  // --------------------
  // Track extremes; a sample in the clear cycle seeds fresh limits
  // --------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      min_ff <= spc_pkg::RST_MIN;
      max_ff <= spc_pkg::RST_MAX;
    end else if (lim.clear) begin
      // Sample wins over clear so an extreme is never lost
      min_ff <= lim.sample ? lim.value : spc_pkg::RST_MIN;
      max_ff <= lim.sample ? lim.value : spc_pkg::RST_MAX;
    end else if (lim.sample) begin
      if (lim.value < min_ff) begin
        min_ff <= lim.value;
      end
      if (lim.value > max_ff) begin
        max_ff <= lim.value;
      end
    end
  end

endmodule : spc_lim_track

// *** spc_pin_src.sv ***
// Pin-2 source model: holds the pin at its active level for a commanded number of cycles
`timescale 1ns/1ns
module spc_pin_src (
  input  wire logic       ref_clk_in,
  input  wire logic       go_in,      // Start a hold
  input  wire logic [7:0] cyc_in,     // Hold length in cycles
  input  wire logic       act_lvl_in, // Level seen as active
  output logic            pin2_out
);
  logic [7:0] cnt_ff = 8'h00; // Remaining hold cycles
  // --------------------
  // Hold timer; changes just after the rising edge, the pin is asynchronous anyway
  // --------------------
  always @(posedge ref_clk_in) begin
    if (go_in) begin
      cnt_ff <= cyc_in;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
  // Idle level is the inverse of the active one, so idle never starts a hold
  assign pin2_out = (cnt_ff != 8'h00) ? act_lvl_in : !act_lvl_in;
endmodule : spc_pin_src

// *** spc_pkg.sv ***
// Package with constants and types for the sensor parameter and pin-2 control block
// What this block does
// - Limits record: min high word, max low
// - Track lowest and highest measured value
// - Command 163 on index 2 clears limits
// - Polarity 0 high-active, 1 low-active
// - Enable 0 ignores pin except as plain input, 16 acts
// - Hold 0.1 to 2 s: teach-in
// - Hold 2 to 4 s: toggle principle
// - Hold over 4 s: toggle NO/NC
// - Pin at ground locks potentiometer
// - Pin may serve as plain digital input
// - Refusal code 0x80, plain additional 0x00
// - Unknown index refused with 0x11
// - Unknown subindex refused with 0x12
// - Wrong access direction refused with 0x23
// - Out of range refused 0x30/0x31
// - Too long 0x33, too short 0x34
// - Unsupported 0x35, busy command 0x36
// - Conflicting single write gives 0x40
// - Failed block plausibility gives 0x41
package spc_pkg;

  // --------------------
  // Parameter indices
  // --------------------
  localparam logic [7:0] IDX_SYS_CMD    = 8'h02; // System command
  localparam logic [7:0] IDX_IN_ENABLE  = 8'h47; // config_input_enable
  localparam logic [7:0] IDX_IN_POL     = 8'h4c; // config_input_polarity
  localparam logic [7:0] IDX_LIMITS     = 8'h54; // measured_value_limits

  // --------------------
  // Values and reset values
  // --------------------
  localparam logic [7:0] CMD_CLR_DIAG   = 8'ha3; // Reset diagnostics (163)
  localparam logic [7:0] EN_OFF         = 8'h00; // Pin ignored
  localparam logic [7:0] EN_ON          = 8'h10; // Pin active
  localparam logic [7:0] POL_HIGH       = 8'h00; // High-active
  localparam logic [7:0] POL_LOW        = 8'h01; // Low-active
  localparam logic [7:0] RST_IN_ENABLE  = 8'h10;
  localparam logic [7:0] RST_IN_POL     = 8'h00;
  localparam logic [31:0] RST_MIN       = 32'hffff_ffff; // Empty min
  localparam logic [31:0] RST_MAX       = 32'h0000_0000; // Empty max

  // Record layout: subindex 1 at bit offset 32, subindex 2 at 0
  localparam int LIM_MIN_LSB = 32;
  localparam int LIM_MAX_LSB = 0;
  localparam logic [7:0] SUB_WHOLE = 8'h00;
  localparam logic [7:0] SUB_MIN   = 8'h01;
  localparam logic [7:0] SUB_MAX   = 8'h02;

  // Defined data lengths in octets
  localparam logic [3:0] LEN_BYTE   = 4'h1;
  localparam logic [3:0] LEN_LIMITS = 4'h8;
  localparam logic [3:0] LEN_WORD   = 4'h4;

  // --------------------
  // Error codes
  // --------------------
  localparam logic [7:0] ERR_CODE      = 8'h80;
  localparam logic [7:0] ADD_NONE      = 8'h00;
  localparam logic [7:0] ADD_IDX       = 8'h11;
  localparam logic [7:0] ADD_SUB       = 8'h12;
  localparam logic [7:0] ADD_ACCESS    = 8'h23;
  localparam logic [7:0] ADD_RANGE     = 8'h30;
  localparam logic [7:0] ADD_ABOVE     = 8'h31;
  localparam logic [7:0] ADD_BELOW     = 8'h32;
  localparam logic [7:0] ADD_LONG      = 8'h33;
  localparam logic [7:0] ADD_SHORT     = 8'h34;
  localparam logic [7:0] ADD_NOFUNC    = 8'h35;
  localparam logic [7:0] ADD_BUSY      = 8'h36;
  localparam logic [7:0] ADD_CONFLICT  = 8'h40;
  localparam logic [7:0] ADD_INCONSIST = 8'h41;

  // --------------------
  // Timing
  // --------------------
  localparam int CLK_HZ     = 10_000_000;
  localparam int T_TEACH_MS = 100;   // Lower bound of teach band
  localparam int T_PRIN_MS  = 2000;  // Start of principle band
  localparam int T_NONC_MS  = 4000;  // Start of NO/NC band
  localparam int CYC_TEACH  = T_TEACH_MS * (CLK_HZ / 1000);
  localparam int CYC_PRIN   = T_PRIN_MS * (CLK_HZ / 1000);
  localparam int CYC_NONC   = T_NONC_MS * (CLK_HZ / 1000);

  // Pin-2 hold timer states
  typedef enum logic [1:0] {
    SPC_IDLE = 2'b00, // Waiting for active level
    SPC_HOLD = 2'b01, // Counting hold time
    SPC_WAIT = 2'b10  // Idle until pin inactive again
  } spc_hold_t;

endpackage : spc_pkg

// *** spc_top.sv ***
// Parameter service and pin-2 configuration input of the ring sensor
`timescale 1ns/1ns
module spc_top #(
  parameter int CYC_TEACH = spc_pkg::CYC_TEACH, // Cycles for 0.1 s
  parameter int CYC_PRIN  = spc_pkg::CYC_PRIN,  // Cycles for 2 s
  parameter int CYC_NONC  = spc_pkg::CYC_NONC   // Cycles for 4 s
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // Parameter service request
  input  wire logic        req_in,        // One-cycle request strobe
  input  wire logic        req_write_in,  // 1 write, 0 read
  input  wire logic [7:0]  req_index_in,
  input  wire logic [7:0]  req_sub_in,
  input  wire logic [3:0]  req_len_in,    // Written length in octets
  input  wire logic [63:0] req_data_in,   // Write data, right aligned
  input  wire logic        req_block_end_in, // End of block transfer
  input  wire logic        app_busy_in,   // Application cannot run commands
  input  wire logic        pin2_func_in,  // 1: pin 2 is a plain input
  // Measurement
  input  wire logic        meas_valid_in,
  input  wire logic [31:0] meas_value_in,
  // Pin 2 level
  input  wire logic        pin2_in,
  // Answer
  output logic             rsp_valid_out, // One-cycle answer strobe
  output logic             rsp_err_out,
  output logic [7:0]       rsp_code_out,
  output logic [7:0]       rsp_add_out,
  output logic [63:0]      rsp_data_out,
  // Pin-2 actions
  output logic             teach_out,     // One-cycle pulse
  output logic             principle_static_out, // 1 static, 0 dynamic
  output logic             output_nc_out,  // 1 NC, 0 NO
  output logic             pot_lock_out,
  output logic             pin2_di_out,    // Plain digital input value
  output logic             diag_clear_out  // One-cycle pulse
);

  // --------------------
  // Declarations
  // --------------------
  localparam int CNT_W = $clog2(CYC_NONC + 2);

  spc_lim_if lim ();

  logic [7:0]       in_en_ff;      // config_input_enable
  logic [7:0]       in_pol_ff;     // config_input_polarity
  logic             pin_s1_ff;     // Synchroniser first stage
  logic             pin_s2_ff;     // Synchroniser second stage
  logic             pin_act;       // Pin in active level
  logic [CNT_W-1:0] cnt_ff;        // Hold time counter
  spc_pkg::spc_hold_t hold_ff;
  logic             teach_ff;
  logic             static_ff;
  logic             nc_ff;
  logic             lock_ff;
  logic             di_ff;
  logic             clr_ff;
  logic             rv_ff;
  logic             re_ff;
  logic [7:0]       rc_ff;
  logic [7:0]       ra_ff;
  logic [63:0]      rd_ff;
  logic             nxt_err;
  logic [7:0]       nxt_add;
  logic [63:0]      nxt_data;
  logic             do_clear;      // Accepted diagnostics reset
  logic             do_en;         // Accepted enable write
  logic             do_pol;        // Accepted polarity write
  logic [7:0]       wbyte;

  assign wbyte = req_data_in[7:0];

  // --------------------
  // Limit tracker
  // --------------------
  assign lim.sample = meas_valid_in;
  assign lim.value  = meas_value_in;
  assign lim.clear  = do_clear;

  spc_lim_track spc_lim_track_i (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .lim        (lim)
  );

  // --------------------
  // Request decode
  // --------------------
  // Checks run in fixed order: index, subindex, access, length, value
  always_comb begin
    nxt_err  = 1'b0;
    nxt_add  = spc_pkg::ADD_NONE;
    nxt_data = 64'h0;
    do_clear = 1'b0;
    do_en    = 1'b0;
    do_pol   = 1'b0;
    if (req_in && req_block_end_in) begin
      // Plausibility: low-active polarity needs an enabled pin
      if (in_en_ff == spc_pkg::EN_OFF && in_pol_ff == spc_pkg::POL_LOW) begin
        nxt_err = 1'b1;
        nxt_add = spc_pkg::ADD_INCONSIST;
      end
    end else if (req_in) begin
      case (req_index_in)
        spc_pkg::IDX_LIMITS: begin
          if (req_sub_in > spc_pkg::SUB_MAX) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_SUB;
          end else if (req_write_in) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_ACCESS;
          end else if (req_sub_in == spc_pkg::SUB_MIN) begin
            nxt_data = {32'h0, lim.min};
          end else if (req_sub_in == spc_pkg::SUB_MAX) begin
            nxt_data = {32'h0, lim.max};
          end else begin
            nxt_data[spc_pkg::LIM_MIN_LSB +: 32] = lim.min;
            nxt_data[spc_pkg::LIM_MAX_LSB +: 32] = lim.max;
          end
        end
        spc_pkg::IDX_SYS_CMD: begin
          if (req_sub_in != spc_pkg::SUB_WHOLE) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_SUB;
          end else if (!req_write_in) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_ACCESS;
          end else if (req_len_in > spc_pkg::LEN_BYTE) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_LONG;
          end else if (req_len_in < spc_pkg::LEN_BYTE) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_SHORT;
          end else if (wbyte != spc_pkg::CMD_CLR_DIAG) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_NOFUNC;
          end else if (app_busy_in) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_BUSY;
          end else begin
            do_clear = 1'b1;
          end
        end
        spc_pkg::IDX_IN_ENABLE, spc_pkg::IDX_IN_POL: begin
          if (req_sub_in != spc_pkg::SUB_WHOLE) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_SUB;
          end else if (!req_write_in) begin
            nxt_data = {56'h0, (req_index_in == spc_pkg::IDX_IN_POL) ? in_pol_ff : in_en_ff};
          end else if (req_len_in > spc_pkg::LEN_BYTE) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_LONG;
          end else if (req_len_in < spc_pkg::LEN_BYTE) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_SHORT;
          end else if (req_index_in == spc_pkg::IDX_IN_POL) begin
            if (wbyte > spc_pkg::POL_LOW) begin
              nxt_err = 1'b1;
              nxt_add = spc_pkg::ADD_ABOVE;
            end else if (wbyte == spc_pkg::POL_LOW && in_en_ff == spc_pkg::EN_OFF) begin
              // Low-active with pin disabled is refused; the lock needs an enabled pin and ignores polarity anyway
              nxt_err = 1'b1;
              nxt_add = spc_pkg::ADD_CONFLICT;
            end else begin
              do_pol = 1'b1;
            end
          end else if (wbyte > spc_pkg::EN_ON) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_ABOVE;
          end else if (wbyte != spc_pkg::EN_OFF && wbyte != spc_pkg::EN_ON) begin
            nxt_err = 1'b1;
            nxt_add = spc_pkg::ADD_RANGE;
          end else begin
            do_en = 1'b1;
          end
        end
        default: begin
          nxt_err = 1'b1;
          nxt_add = spc_pkg::ADD_IDX;
        end
      endcase
    end
  end

  // --------------------
  // Answer registers
  // --------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rv_ff <= 1'b0;
      re_ff <= 1'b0;
      rc_ff <= 8'h00;
      ra_ff <= 8'h00;
      rd_ff <= 64'h0;
    end else begin
      rv_ff <= req_in;
      re_ff <= req_in & nxt_err;
      rc_ff <= (req_in && nxt_err) ? spc_pkg::ERR_CODE : 8'h00;
      ra_ff <= req_in ? nxt_add : 8'h00;
      rd_ff <= req_in ? nxt_data : 64'h0;
    end
  end

  // --------------------
  // Parameter registers and diagnostics pulse
  // --------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_en_ff  <= spc_pkg::RST_IN_ENABLE;
      in_pol_ff <= spc_pkg::RST_IN_POL;
      clr_ff    <= 1'b0;
    end else begin
      if (do_en) begin
        in_en_ff <= wbyte;
      end
      if (do_pol) begin
        in_pol_ff <= wbyte;
      end
      clr_ff <= do_clear;
    end
  end

  // --------------------
  // Pin 2 synchroniser
  // --------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= pin2_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign pin_act = (in_pol_ff == spc_pkg::POL_LOW) ? ~pin_s2_ff : pin_s2_ff;

  // --------------------
  // Hold timer: one action decided only at release
  // --------------------
  // Counter saturates past the 4 s mark so long holds stay in band
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_ff   <= spc_pkg::SPC_IDLE;
      cnt_ff    <= '0;
      teach_ff  <= 1'b0;
      static_ff <= 1'b0;
      nc_ff     <= 1'b0;
    end else begin
      teach_ff <= 1'b0;
      case (hold_ff)
        spc_pkg::SPC_IDLE: begin
          cnt_ff <= '0;
          if (in_en_ff != spc_pkg::EN_ON || pin2_func_in) begin
            hold_ff <= spc_pkg::SPC_IDLE;
          end else if (pin_act) begin
            hold_ff <= spc_pkg::SPC_HOLD;
          end
        end
        spc_pkg::SPC_HOLD: begin
          if (in_en_ff != spc_pkg::EN_ON || pin2_func_in) begin
            hold_ff <= spc_pkg::SPC_WAIT; // Abort without action
          end else if (pin_act) begin
            if (cnt_ff <= CNT_W'(CYC_NONC)) begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end else begin
            hold_ff <= spc_pkg::SPC_IDLE;
            if (cnt_ff > CNT_W'(CYC_NONC)) begin
              nc_ff <= ~nc_ff;
            end else if (cnt_ff >= CNT_W'(CYC_PRIN)) begin
              static_ff <= ~static_ff;
            end else if (cnt_ff >= CNT_W'(CYC_TEACH)) begin
              teach_ff <= 1'b1;
            end
          end
        end
        spc_pkg::SPC_WAIT: begin
          cnt_ff <= '0;
          if (!pin_act) begin
            hold_ff <= spc_pkg::SPC_IDLE;
          end
        end
        default: begin
          hold_ff <= spc_pkg::SPC_IDLE;
          cnt_ff  <= '0;
        end
      endcase
    end
  end

  // --------------------
  // Potentiometer lock and plain input function
  // --------------------
  // Lock follows the raw ground level, independent of polarity
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_ff <= 1'b0;
      di_ff   <= 1'b0;
    end else begin
      lock_ff <= (in_en_ff == spc_pkg::EN_ON) && !pin2_func_in && !pin_s2_ff;
      di_ff   <= pin2_func_in & pin_act;
    end
  end

  // --------------------
  // Outputs
  // --------------------
  assign rsp_valid_out        = rv_ff;
  assign rsp_err_out          = re_ff;
  assign rsp_code_out         = rc_ff;
  assign rsp_add_out          = ra_ff;
  assign rsp_data_out         = rd_ff;
  assign teach_out            = teach_ff;
  assign principle_static_out = static_ff;
  assign output_nc_out        = nc_ff;
  assign pot_lock_out         = lock_ff;
  assign pin2_di_out          = di_ff;
  assign diag_clear_out       = clr_ff;

endmodule : spc_top

// *** spc_top_tb.sv ***
// Self-checking testbench for the parameter service and pin-2 control block
`timescale 1ns/1ns
module spc_top_tb;
  logic        ref_clk_in, rstn_in, req_in, req_write_in, req_block_end_in, app_busy_in;
  logic        pin2_func_in, meas_valid_in, pin2_in, go, act_lvl;
  logic [7:0]  req_index_in, req_sub_in, cyc;
  logic [3:0]  req_len_in;
  logic [63:0] req_data_in, rsp_data_out;
  logic [31:0] meas_value_in, mn, mx;
  logic        rsp_valid_out, rsp_err_out, teach_out, principle_static_out, output_nc_out;
  logic        pot_lock_out, pin2_di_out, diag_clear_out, prev_s = 1'b0, prev_n = 1'b0;
  logic [7:0]  rsp_code_out, rsp_add_out;
  logic [80:0] rsp_q[$];  // Expected answers, oldest first
  logic [2:0]  act_q[$];  // Expected actions {teach, static, nc}
  logic [2:0]  ev;
  integer      seed = 32'hd198;
  int          err_count = 0, n_tests = 0, cycles = 0;

  spc_top #(.CYC_TEACH(10), .CYC_PRIN(40), .CYC_NONC(80)) spc_top_i (.*);
  spc_pin_src spc_pin_src_i (.ref_clk_in(ref_clk_in), .go_in(go), .cyc_in(cyc),
    .act_lvl_in(act_lvl), .pin2_out(pin2_in));

  // --------------------
  // Clock, timeout and verdict
  // --------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = !ref_clk_in;
  end
  // Whole run needs under a thousand cycles; five times that means a hang
  always @(posedge ref_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [80:0] seen, input logic [80:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // --------------------
  // Drivers: one request per falling edge, expectation noted with it
  // --------------------
  task automatic svc(input logic b, w, input logic [7:0] idx, sub, input logic [3:0] len,
                     input logic [63:0] d, input logic e, input logic [7:0] add, input logic [63:0] rd);
    @(negedge ref_clk_in);
    req_in = 1'b1;
    {req_block_end_in, req_write_in, req_index_in, req_sub_in, req_len_in, req_data_in} = {b, w, idx, sub, len, d};
    rsp_q.push_back({e, e ? 8'h80 : 8'h00, add, rd});
  endtask : svc
  task automatic rel();
    @(negedge ref_clk_in);
    req_in = 1'b0;
  endtask : rel
  // Hold the pin active for n cycles, then let any action land
  task automatic hold(input logic [7:0] n, input logic [2:0] act);
    @(negedge ref_clk_in);
    go = 1'b1;
    cyc = n;
    if (act != 3'b000) act_q.push_back(act);
    @(negedge ref_clk_in);
    go = 1'b0;
    repeat (int'(n) + 30) @(negedge ref_clk_in);
  endtask : hold

  // --------------------
  // Monitor: every answer or action takes the oldest note; a missing note is a mismatch
  // --------------------
  always @(negedge ref_clk_in) begin
    ev = {teach_out, principle_static_out !== prev_s, output_nc_out !== prev_n};
    prev_s = principle_static_out;
    prev_n = output_nc_out;
    if (rstn_in && rsp_valid_out === 1'b1) begin
      if (rsp_q.size() == 0) check(81'h1, 81'h0);
      else check({rsp_err_out, rsp_code_out, rsp_add_out, rsp_data_out}, rsp_q.pop_front());
    end
    if (rstn_in && ev != 3'b000) begin
      if (act_q.size() == 0) check(81'(ev), 81'h0);
      else check(81'(ev), 81'(act_q.pop_front()));
    end
  end

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    {rstn_in, req_in, req_write_in, req_block_end_in, app_busy_in, pin2_func_in, meas_valid_in, go} = 8'h00;
    {req_index_in, req_sub_in, cyc, req_len_in, req_data_in, meas_value_in} = '0;
    act_lvl = 1'b1;
    {mn, mx} = {32'hffff_ffff, 32'h0};
    repeat (12) @(posedge ref_clk_in);
    @(negedge ref_clk_in) rstn_in = 1'b1;
    svc(0, 0, 8'h47, 8'h00, 4'h1, 64'h0, 0, 8'h00, 64'h10);
    svc(0, 0, 8'h4c, 8'h00, 4'h1, 64'h0, 0, 8'h00, 64'h0);
    svc(0, 0, 8'h54, 8'h00, 4'h8, 64'h0, 0, 8'h00, {mn, mx});
    rel();
    // Random measured values; reference extremes kept here
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_in);
      meas_valid_in = 1'b1;
      meas_value_in = $random(seed);
      if (meas_value_in < mn) mn = meas_value_in;
      if (meas_value_in > mx) mx = meas_value_in;
    end
    @(negedge ref_clk_in) meas_valid_in = 1'b0;
    svc(0, 0, 8'h54, 8'h00, 4'h8, 64'h0, 0, 8'h00, {mn, mx});
    svc(0, 0, 8'h54, 8'h01, 4'h4, 64'h0, 0, 8'h00, {32'h0, mn});
    svc(0, 0, 8'h54, 8'h02, 4'h4, 64'h0, 0, 8'h00, {32'h0, mx});
    svc(0, 1, 8'h02, 8'h00, 4'h1, 64'ha3, 0, 8'h00, 64'h0);
    svc(0, 0, 8'h54, 8'h00, 4'h8, 64'h0, 0, 8'h00, {32'hffff_ffff, 32'h0});
    svc(0, 1, 8'h02, 8'h00, 4'h1, 64'h41, 1, 8'h35, 64'h0);
    rel();
    app_busy_in = 1'b1;
    svc(0, 1, 8'h02, 8'h00, 4'h1, 64'ha3, 1, 8'h36, 64'h0);
    rel();
    app_busy_in = 1'b0;
    svc(0, 0, 8'h10, 8'h00, 4'h1, 64'h0, 1, 8'h11, 64'h0);
    svc(0, 1, 8'h54, 8'h03, 4'h8, 64'h0, 1, 8'h12, 64'h0);
    svc(0, 0, 8'h47, 8'h01, 4'h1, 64'h0, 1, 8'h12, 64'h0);
    svc(0, 1, 8'h54, 8'h01, 4'h4, 64'h0, 1, 8'h23, 64'h0);
    svc(0, 0, 8'h02, 8'h00, 4'h1, 64'h0, 1, 8'h23, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h2, 64'h10, 1, 8'h33, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h0, 64'h10, 1, 8'h34, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h20, 1, 8'h31, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h05, 1, 8'h30, 64'h0);
    svc(0, 1, 8'h4c, 8'h00, 4'h1, 64'h02, 1, 8'h31, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h00, 0, 8'h00, 64'h0);
    svc(0, 1, 8'h4c, 8'h00, 4'h1, 64'h01, 1, 8'h40, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h10, 0, 8'h00, 64'h0);
    svc(0, 1, 8'h4c, 8'h00, 4'h1, 64'h01, 0, 8'h00, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h00, 0, 8'h00, 64'h0);
    svc(1, 0, 8'h00, 8'h00, 4'h0, 64'h0, 1, 8'h41, 64'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h10, 0, 8'h00, 64'h0);
    svc(1, 0, 8'h00, 8'h00, 4'h0, 64'h0, 0, 8'h00, 64'h0);
    svc(0, 1, 8'h4c, 8'h00, 4'h1, 64'h00, 0, 8'h00, 64'h0);
    rel();
    // Hold bands with the high-active default polarity
    repeat (10) @(negedge ref_clk_in);
    check(81'(pot_lock_out), 81'h1);
    hold(8'd5, 3'b000);
    hold(8'd20, 3'b100);
    hold(8'd60, 3'b010);
    hold(8'd100, 3'b001);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h00, 0, 8'h00, 64'h0);
    rel();
    hold(8'd20, 3'b000);
    check(81'(pot_lock_out), 81'h0);
    svc(0, 1, 8'h47, 8'h00, 4'h1, 64'h10, 0, 8'h00, 64'h0);
    rel();
    pin2_func_in = 1'b1;
    // Plain input mode: the pin level must show on the digital input output
    fork
      hold(8'd60, 3'b000);
      begin
        repeat (20) @(negedge ref_clk_in);
        check(81'(pin2_di_out), 81'h1);
      end
    join
    check(81'(pin2_di_out), 81'h0);
    pin2_func_in = 1'b0;
    // Low-active polarity: idle pin is high, so the lock is released
    svc(0, 1, 8'h4c, 8'h00, 4'h1, 64'h01, 0, 8'h00, 64'h0);
    act_lvl = 1'b0;
    rel();
    repeat (10) @(negedge ref_clk_in);
    check(81'(pot_lock_out), 81'h0);
    hold(8'd20, 3'b100);
    check(81'(rsp_q.size() + act_q.size()), 81'h0);
    give_verdict();
  end
endmodule : spc_top_tb
